// File: hw/eep_pkg.sv
// Constants, types and helpers for the two-wire EEPROM slave
// Behaviour
// (RULE1) Answer only address 1010 001 plus direction
// (RULE2) Acknowledge address, pointer and accepted data
// (RULE3) Sample on rise, drive on fall, open-drain
// (RULE4) Byte write: four bytes acked, stop programs
// (RULE5) No address acknowledge while programming runs
// (RULE6) 8192 bytes as 128 pages of 64
// (RULE7) Write pointer wraps inside the page
// (RULE8) Pointer bit 15 selects array or register
// (RULE9) Register: enable, high, low select, lock
// (RULE10) Enable bit zero leaves whole array writable
// (RULE11) Block selects pick protected upper range
// (RULE12) Lock bit set freezes control bits forever
// (RULE13) Protected data byte: no acknowledge, discard
// (RULE14) Register update needs exactly one data byte
// (RULE15) Read without pointer load returns current byte
// (RULE16) Pointer load then repeated start reads there
// (RULE17) Acked reads advance, wrapping at array end
// (RULE18) Register read repeats the register value
// (RULE19) Delivered erased array, register cleared
// (RULE20) Pointer ends past the last byte accessed
package eep_pkg;
  // Clock and program cycle time
  localparam int CLK_NS = 8;
  localparam int T_WR_NS = 5000000;
  localparam int WR_CYC = T_WR_NS / CLK_NS;
  // Bus address and array shape
  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_BYTES = 64;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [3:0] PROT_REG_RST = 4'h0;
  // Pointer high byte bit that selects the register
  localparam int SEL_BIT = 7;
  // Control register bit positions
  localparam int EN_BIT = 3;
  localparam int LOCK_BIT = 0;
  // Lowest protected address per block select
  localparam logic [12:0] PROT_Q = 13'h1800;
  localparam logic [12:0] PROT_H = 13'h1000;
  localparam logic [12:0] PROT_3Q = 13'h0800;
  localparam logic [12:0] PROT_ALL = 13'h0000;
  // Byte position within a write session
  localparam logic [1:0] PH_DEV = 2'h0;
  localparam logic [1:0] PH_AHI = 2'h1;
  localparam logic [1:0] PH_ALO = 2'h2;
  localparam logic [1:0] PH_DAT = 2'h3;
  // Bit engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_NINTH = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } eep_state_e;
  // True when an array address is write protected
  function automatic logic prot_hit(input logic [12:0] a,
                                    input logic [3:0] w);
    logic [12:0] lim;
    lim = PROT_ALL;
    // (RULE11) block select ranges
    case (w[2:1])
      2'h0: lim = PROT_Q;
      2'h1: lim = PROT_H;
      2'h2: lim = PROT_3Q;
      default: lim = PROT_ALL;
    endcase
    // (RULE10) enable gates protection
    return w[EN_BIT] && (a >= lim);
  endfunction
endpackage

// File: hw/eep_link_if.sv
// Carrier between pin front end, program timer and core
`timescale 1ns/1ns
`default_nettype none
interface eep_link_if;
  logic scl_rise;  // Clock rose, one cycle
  logic scl_fall;  // Clock fell, one cycle
  logic start_ev;  // Start condition, one cycle
  logic stop_ev;   // Stop condition, one cycle
  logic sda_level; // Synchronised data line
  logic prog_start; // Launch a program cycle
  logic prog_busy; // Program cycle running
  modport sync (output scl_rise, scl_fall, start_ev, stop_ev,
                sda_level);
  modport timer (input prog_start, output prog_busy);
  modport core (input scl_rise, scl_fall, start_ev, stop_ev,
                sda_level, prog_busy, output prog_start);
endinterface
`default_nettype wire

// File: hw/eep_pin_sync.sv
// Pin synchronisers and bus event detection
`timescale 1ns/1ns
`default_nettype none
module eep_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic scl_i,
  input wire logic sda_i,
  // Events to the core
  eep_link_if.sync lnk
);
  // -----------------------------------------
  // Synchroniser chains
  // -----------------------------------------
  logic [2:0] scl_ff;
  logic [2:0] sda_ff;
  logic [2:0] nxt_scl;
  logic [2:0] nxt_sda;

  // Shift one stage per clock; stage 0 feeds only stage 1
  always_comb begin
    nxt_scl = {scl_ff[1:0], scl_i};
    nxt_sda = {sda_ff[1:0], sda_i};
  end

  // Idle bus reads high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_ff <= 3'h7;
      sda_ff <= 3'h7;
    end else begin
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
    end
  end

  // -----------------------------------------
  // Edges and conditions
  // -----------------------------------------
  // (RULE3) edges of the bus clock
  assign lnk.scl_rise = scl_ff[1] & ~scl_ff[2];
  assign lnk.scl_fall = ~scl_ff[1] & scl_ff[2];
  // Data moving while clock stays high
  assign lnk.start_ev = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
  assign lnk.stop_ev = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];
  assign lnk.sda_level = sda_ff[1];
endmodule // eep_pin_sync
`default_nettype wire

// File: hw/eep_prog_timer.sv
// Internal program cycle timer
`timescale 1ns/1ns
`default_nettype none
module eep_prog_timer #(
  parameter int CYCLES = eep_pkg::WR_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Launch and busy
  eep_link_if.timer lnk
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Load on launch, then count down to idle
  always_comb begin
    nxt_cnt = cnt_ff;
    if (lnk.prog_start && cnt_ff == '0) begin
      nxt_cnt = W'(CYCLES);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // (RULE5) busy window for the core
  assign lnk.prog_busy = cnt_ff != '0;
endmodule // eep_prog_timer
`default_nettype wire

// File: hw/eep_top.sv
// Two-wire EEPROM slave with protect register
`timescale 1ns/1ns
`default_nettype none
module eep_top #(
  parameter int WR_CYCLES = eep_pkg::WR_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins, data is open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Status
  output logic wr_busy
);
  // -----------------------------------------
  // Reset release
  // -----------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n_int;

  // Two stages release reset on our clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_ff[1];

  // -----------------------------------------
  // Sub blocks
  // -----------------------------------------
  eep_link_if lnk ();

  eep_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n_int),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .lnk(lnk.sync)
  );

  eep_prog_timer #(.CYCLES(WR_CYCLES)) u_tmr (
    .clk(clk),
    .rst_n(rst_n_int),
    .lnk(lnk.timer)
  );

  // -----------------------------------------
  // Storage
  // -----------------------------------------
  // (RULE6) array and page buffer
  // (RULE19) delivered erased and unprotected, never reset
  logic [7:0] mem [0:eep_pkg::MEM_BYTES-1] = '{default: eep_pkg::ERASED};
  logic [7:0] pbuf [0:eep_pkg::PAGE_BYTES-1];
  // Protect control, kept over reset
  logic [3:0] prot_reg_ff = eep_pkg::PROT_REG_RST;
  logic pbuf_we; // Load a byte into the page buffer
  logic prot_reg_we; // Commit the protect register

  // -----------------------------------------
  // Engine state
  // -----------------------------------------
  eep_pkg::eep_state_e st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt; // Bits of the current byte
  logic [7:0] sh_ff, nxt_sh; // Shift register
  logic [1:0] ph_ff, nxt_ph; // Byte position in session
  logic [12:0] addr_ff, nxt_addr; // Current address
  logic regsel_ff, nxt_regsel; // Register targeted
  logic txn_ff, nxt_txn; // Send a byte after ninth clock
  logic oe_n_ff, nxt_oe_n; // Data pin release
  logic rej_ff, nxt_rej; // Write request rejected
  logic [63:0] pmask_ff, nxt_pmask; // Loaded page bytes
  logic [1:0] wcnt_ff, nxt_wcnt; // Register data bytes
  logic [3:0] wnew_ff, nxt_wnew; // Register value to commit
  logic cmt_ff, nxt_cmt; // Array commit running
  logic [5:0] cidx_ff, nxt_cidx; // Commit byte index
  logic prog_go; // Program launch request
  logic [7:0] rd_byte; // Byte to send next
  logic ev_any; // Clock fall, start or stop this cycle
  logic ev_eval; // Received byte decided this cycle

  assign ev_any = lnk.scl_fall | lnk.start_ev | lnk.stop_ev;
  assign ev_eval = (st_ff == eep_pkg::ST_RX) && lnk.scl_fall &&
                   (cnt_ff == 4'h8) && !lnk.start_ev && !lnk.stop_ev;

  // (RULE9) upper four bits read as zero
  // (RULE18) register reads as four zero bits and control
  assign rd_byte = regsel_ff ? {4'h0, prot_reg_ff} : mem[addr_ff];

  // Next state of the bit engine
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ph = ph_ff;
    nxt_addr = addr_ff;
    nxt_regsel = regsel_ff;
    nxt_txn = txn_ff;
    nxt_oe_n = oe_n_ff;
    nxt_rej = rej_ff;
    nxt_pmask = pmask_ff;
    nxt_wcnt = wcnt_ff;
    nxt_wnew = wnew_ff;
    nxt_cmt = cmt_ff;
    nxt_cidx = cidx_ff;
    prog_go = 1'b0;
    pbuf_we = 1'b0;
    prot_reg_we = 1'b0;
    // Commit walks the page, one byte per cycle
    if (cmt_ff) begin
      nxt_cidx = cidx_ff + 6'h1;
      if (cidx_ff == 6'h3f) begin
        nxt_cmt = 1'b0;
        nxt_pmask = '0;
      end
    end
    if (lnk.start_ev) begin
      // Start or repeated start: expect an address
      nxt_st = eep_pkg::ST_RX;
      nxt_cnt = 4'h0;
      nxt_ph = eep_pkg::PH_DEV;
      nxt_oe_n = 1'b1;
    end else if (lnk.stop_ev) begin
      // (RULE15) stop returns to standby
      nxt_st = eep_pkg::ST_IDLE;
      nxt_oe_n = 1'b1;
      // (RULE4) stop launches programming
      if (!rej_ff && !lnk.prog_busy &&
          (pmask_ff != '0 || wcnt_ff == 2'h1)) begin
        prog_go = 1'b1;
        nxt_cmt = pmask_ff != '0;
        nxt_cidx = 6'h0;
        nxt_wcnt = 2'h0;
        // (RULE12) locked register never changes
        prot_reg_we = (wcnt_ff == 2'h1) &&
                      !prot_reg_ff[eep_pkg::LOCK_BIT];
      end
    end else begin
      case (st_ff)
        eep_pkg::ST_RX: begin
          if (lnk.scl_rise) begin
            // (RULE3) sample on rising clock
            nxt_sh = {sh_ff[6:0], lnk.sda_level};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (ev_eval) begin
            nxt_cnt = 4'h0;
            nxt_oe_n = 1'b1;
            nxt_st = eep_pkg::ST_IDLE;
            nxt_txn = 1'b0;
            case (ph_ff)
              eep_pkg::PH_DEV: begin
                // (RULE1) match own address only
                // (RULE5) silent while programming
                if (sh_ff[7:1] == eep_pkg::DEV_ADDR &&
                    !lnk.prog_busy) begin
                  nxt_oe_n = 1'b0;
                  nxt_st = eep_pkg::ST_NINTH;
                  // (RULE15) read starts at current address
                  nxt_txn = sh_ff[0];
                  if (!sh_ff[0]) begin
                    nxt_ph = eep_pkg::PH_AHI;
                    nxt_pmask = '0;
                    nxt_rej = 1'b0;
                    nxt_wcnt = 2'h0;
                  end
                end
              end
              eep_pkg::PH_AHI: begin
                // (RULE2) acknowledge both pointer bytes
                // (RULE8) bit 15 selects register, 14..13 ignored
                nxt_regsel = sh_ff[eep_pkg::SEL_BIT];
                nxt_addr = {sh_ff[4:0], addr_ff[7:0]};
                nxt_ph = eep_pkg::PH_ALO;
                nxt_oe_n = 1'b0;
                nxt_st = eep_pkg::ST_NINTH;
              end
              eep_pkg::PH_ALO: begin
                // (RULE16) pointer load for a later read
                nxt_addr = {addr_ff[12:8], sh_ff};
                nxt_ph = eep_pkg::PH_DAT;
                nxt_oe_n = 1'b0;
                nxt_st = eep_pkg::ST_NINTH;
              end
              default: begin
                if (regsel_ff) begin
                  // (RULE14) count bytes, upper nibble ignored
                  if (wcnt_ff != 2'h2) begin
                    nxt_wcnt = wcnt_ff + 2'h1;
                  end
                  nxt_wnew = sh_ff[3:0];
                  nxt_oe_n = 1'b0;
                  nxt_st = eep_pkg::ST_NINTH;
                end else if (eep_pkg::prot_hit(addr_ff, prot_reg_ff)) begin
                  // (RULE13) refuse protected byte
                  nxt_rej = 1'b1;
                end else begin
                  // (RULE7) load byte, wrap inside page
                  pbuf_we = 1'b1;
                  nxt_pmask[addr_ff[5:0]] = 1'b1;
                  nxt_addr = {addr_ff[12:6], addr_ff[5:0] + 6'h1};
                  nxt_oe_n = 1'b0;
                  nxt_st = eep_pkg::ST_NINTH;
                end
              end
            endcase
          end
        end
        eep_pkg::ST_NINTH: begin
          if (lnk.scl_fall) begin
            if (txn_ff) begin
              // (RULE3) first bit driven after falling edge
              nxt_oe_n = rd_byte[7];
              nxt_sh = {rd_byte[6:0], 1'b0};
              nxt_cnt = 4'h1;
              nxt_st = eep_pkg::ST_TX;
              // (RULE17) array pointer wraps at the end
              // (RULE20) pointer left past last byte read
              if (!regsel_ff) begin
                nxt_addr = addr_ff + 13'h1;
              end
            end else begin
              nxt_oe_n = 1'b1;
              nxt_cnt = 4'h0;
              nxt_st = eep_pkg::ST_RX;
            end
          end
        end
        eep_pkg::ST_TX: begin
          if (lnk.scl_fall) begin
            if (cnt_ff == 4'h8) begin
              nxt_oe_n = 1'b1;
              nxt_st = eep_pkg::ST_MACK;
            end else begin
              nxt_oe_n = sh_ff[7];
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        eep_pkg::ST_MACK: begin
          if (lnk.scl_rise) begin
            // Master acknowledge asks for one more byte
            nxt_txn = !lnk.sda_level;
            nxt_st = lnk.sda_level ? eep_pkg::ST_IDLE
                                   : eep_pkg::ST_NINTH;
          end
        end
        default: begin
          nxt_st = eep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register the engine state
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_ff <= eep_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ph_ff <= eep_pkg::PH_DEV;
      addr_ff <= 13'h0000;
      regsel_ff <= 1'b0;
      txn_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      rej_ff <= 1'b0;
      pmask_ff <= '0;
      wcnt_ff <= 2'h0;
      wnew_ff <= 4'h0;
      cmt_ff <= 1'b0;
      cidx_ff <= 6'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ph_ff <= nxt_ph;
      addr_ff <= nxt_addr;
      regsel_ff <= nxt_regsel;
      txn_ff <= nxt_txn;
      oe_n_ff <= nxt_oe_n;
      rej_ff <= nxt_rej;
      pmask_ff <= nxt_pmask;
      wcnt_ff <= nxt_wcnt;
      wnew_ff <= nxt_wnew;
      cmt_ff <= nxt_cmt;
      cidx_ff <= nxt_cidx;
    end
  end

  // Non-volatile writes: page commit, buffer load, register
  always @(posedge clk) begin
    if (cmt_ff && pmask_ff[cidx_ff]) begin
      mem[{addr_ff[12:6], cidx_ff}] <= pbuf[cidx_ff];
    end
    if (pbuf_we) begin
      pbuf[addr_ff[5:0]] <= sh_ff;
    end
    if (prot_reg_we) begin
      prot_reg_ff <= wnew_ff;
    end
  end

  // -----------------------------------------
  // Outputs
  // -----------------------------------------
  assign lnk.prog_start = prog_go;
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_ff;
  assign wr_busy = lnk.prog_busy;

  // -----------------------------------------
  // Checks
  // -----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_int);

  a_addr_only_match: assert property ( // (RULE1)
    ev_eval && ph_ff == eep_pkg::PH_DEV &&
    sh_ff[7:1] != eep_pkg::DEV_ADDR
    |=> st_ff == eep_pkg::ST_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");

  a_ack_pointer: assert property ( // (RULE2)
    ev_eval && (ph_ff == eep_pkg::PH_AHI || ph_ff == eep_pkg::PH_ALO)
    |=> !sda_oe_n && st_ff == eep_pkg::ST_NINTH)
    else $error("pointer byte not acknowledged");

  a_sda_on_fall: assert property ( // (RULE3)
    $changed(oe_n_ff) |-> $past(ev_any))
    else $error("data pin moved without a clock fall");

  a_busy_no_ack: assert property ( // (RULE5)
    ev_eval && ph_ff == eep_pkg::PH_DEV && lnk.prog_busy
    |=> sda_oe_n [*2])
    else $error("address acknowledged while busy");

  a_stop_launch: assert property ( // (RULE4)
    lnk.stop_ev && !rej_ff && !lnk.prog_busy && pmask_ff != '0
    |=> wr_busy && cmt_ff)
    else $error("stop did not launch programming");

  a_page_wrap: assert property ( // (RULE7)
    pbuf_we |=> addr_ff[12:6] == $past(addr_ff[12:6]) &&
    addr_ff[5:0] == $past(addr_ff[5:0]) + 6'h1)
    else $error("write pointer left its page");

  a_prot_refuse: assert property ( // (RULE13)
    ev_eval && ph_ff == eep_pkg::PH_DAT && !regsel_ff &&
    eep_pkg::prot_hit(addr_ff, prot_reg_ff)
    |=> rej_ff && sda_oe_n && !pbuf_we)
    else $error("protected byte accepted");

  a_lock_hold: assert property ( // (RULE12)
    prot_reg_ff[eep_pkg::LOCK_BIT] |=> $stable(prot_reg_ff))
    else $error("locked register changed");

  a_read_incr: assert property ( // (RULE17)
    st_ff == eep_pkg::ST_NINTH && lnk.scl_fall && txn_ff &&
    !regsel_ff && !lnk.start_ev && !lnk.stop_ev
    |=> addr_ff == $past(addr_ff) + 13'h1)
    else $error("read pointer did not advance");

  a_reg_read: assert property ( // (RULE18)
    st_ff == eep_pkg::ST_NINTH && lnk.scl_fall && txn_ff &&
    regsel_ff && !lnk.start_ev && !lnk.stop_ev
    |=> !sda_oe_n && $stable(addr_ff))
    else $error("register read sent a set top bit");

  c_page_write: cover property (prog_go && pmask_ff != '0);
  c_reg_write: cover property (prot_reg_we);
  c_seq_read: cover property (st_ff == eep_pkg::ST_MACK &&
                              lnk.scl_rise && !lnk.sda_level);
  c_prot_hit: cover property (ev_eval && ph_ff == eep_pkg::PH_DAT &&
                              !regsel_ff &&
                              eep_pkg::prot_hit(addr_ff, prot_reg_ff));
endmodule // eep_top
`default_nettype wire

// File: verification/eep_bus_master.sv
// Two-wire bus master model driving clock and data pull-down
`timescale 1ns/1ns
`default_nettype none
module eep_bus_master (
  // System clock for pacing
  input wire logic clk,
  // Bus wires
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  //----------------------------------------------
  // Bit timing, one bus clock is ten system clocks
  //----------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    if (scl === 1'b0) begin
      // Release data, then raise clock
      tick(3);
      sda_pull = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(5);
    end
    sda_pull = 1'b1;
    tick(5);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(3);
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(5);
    sda_pull = 1'b0;
    tick(5);
  endtask
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_pull = !b;
    tick(2);
    scl = 1'b1;
    tick(5);
    s = sda;
    scl = 1'b0;
  endtask
  // Eight bits out and in, then the ninth clock
  task automatic byte_io(input logic [7:0] tx, input logic mack,
                         output logic [7:0] rx, output logic dack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(!mack, s);
    dack = !s;
  endtask
endmodule // eep_bus_master
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // Shortened program cycle
  localparam int WR_CYC = 200;
  logic clk;
  logic rst_n;
  logic scl;
  logic pull;
  logic sda;
  logic sda_o;
  logic sda_oe_n;
  logic wr_busy;
  int error_cnt = 0;
  int checks_done = 0;
  // Resolved data wire with pull-up; device pulls to its sda_o level
  assign sda = (sda_oe_n || sda_o) && !pull;
  eep_top #(.WR_CYCLES(WR_CYC)) u_dut (.clk(clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .wr_busy(wr_busy));
  eep_bus_master u_mst (.clk(clk), .scl(scl), .sda_pull(pull), .sda(sda));
  //----------------------------------------------
  // Shared sequences
  //----------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Start plus device address byte
  task automatic addr(input logic [6:0] dev, input logic rd,
                      output logic ack);
    logic [7:0] rx;
    u_mst.start();
    u_mst.byte_io({dev, rd}, 1'b0, rx, ack);
  endtask
  // Write address plus two pointer bytes, all acknowledged
  task automatic ptr(input logic [15:0] a);
    logic ack;
    logic [7:0] rx;
    addr(7'h51, 1'b0, ack);
    chk("address ack", {7'h00, ack}, 8'h01);
    u_mst.byte_io(a[15:8], 1'b0, rx, ack);
    chk("pointer ack", {7'h00, ack}, 8'h01);
    u_mst.byte_io(a[7:0], 1'b0, rx, ack);
    chk("pointer ack", {7'h00, ack}, 8'h01);
  endtask
  // Write session, every data byte expected to ack as dexp
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$],
                    input logic dexp);
    logic ack;
    logic [7:0] rx;
    ptr(a);
    foreach (d[i]) begin
      u_mst.byte_io(d[i], 1'b0, rx, ack);
      chk("data ack", {7'h00, ack}, {7'h00, dexp});
    end
    u_mst.stop();
  endtask
  // Read session, last byte not acknowledged
  task automatic rd(input logic [7:0] e[$]);
    logic ack;
    logic [7:0] rx;
    addr(7'h51, 1'b1, ack);
    chk("read address ack", {7'h00, ack}, 8'h01);
    foreach (e[i]) begin
      u_mst.byte_io(8'hff, i < e.size() - 1, rx, ack);
      chk("read data", rx, e[i]);
    end
    u_mst.stop();
  endtask
  // poll until the address is acknowledged
  task automatic poll();
    logic ack;
    ack = 1'b0;
    for (int n = 0; n < 40 && ack !== 1'b1; n++) begin
      addr(7'h51, 1'b0, ack);
      u_mst.stop();
    end
    chk("poll ack", {7'h00, ack}, 8'h01);
    chk("busy after poll", {7'h00, wr_busy}, 8'h00);
  endtask
  //----------------------------------------------
  // Scenarios
  //----------------------------------------------
  task automatic t_delivery();
    ptr(16'h0010);
    rd('{8'hff});
    ptr(16'h8000);
    rd('{8'h00, 8'h00});
  endtask
  // Foreign addresses get no acknowledge
  task automatic t_foreign();
    logic ack;
    logic [6:0] bad[3] = '{7'h50, 7'h53, 7'h11};
    foreach (bad[i]) begin
      addr(bad[i], 1'b0, ack);
      u_mst.stop();
      chk("foreign ack", {7'h00, ack}, 8'h00);
    end
  endtask
  // Byte write, refusal while busy, immediate read
  task automatic t_write();
    logic ack;
    wr(16'h6000, '{8'ha5}, 1'b1);
    chk("busy after stop", {7'h00, wr_busy}, 8'h01);
    addr(7'h51, 1'b1, ack);
    u_mst.stop();
    chk("busy address ack", {7'h00, ack}, 8'h00);
    poll();
    ptr(16'h0000);
    rd('{8'ha5});
    rd('{8'hff});
  endtask
  // Page wrap on write, array wrap on read
  task automatic t_page();
    wr(16'h1fff, '{8'h02, 8'h03}, 1'b1);
    poll();
    ptr(16'h1fff);
    rd('{8'h02, 8'ha5, 8'hff});
    ptr(16'h1fc0);
    rd('{8'h03});
  endtask
  // Every block select, edge of each range
  task automatic t_protect();
    logic [12:0] lim[4] = '{13'h1800, 13'h1000, 13'h0800, 13'h0000};
    for (int s = 0; s < 4; s++) begin
      wr(16'h8000, '{{5'h1f, s[1:0], 1'b0}}, 1'b1);
      poll();
      ptr(16'hffff);
      rd('{{5'h01, s[1:0], 1'b0}});
      wr({3'h0, lim[s]}, '{8'h3c}, 1'b0);
      poll();
      if (lim[s] != 13'h0000) begin
        wr({3'h0, lim[s] - 13'h0001}, '{8'h3c}, 1'b1);
        poll();
      end
    end
    ptr(16'h1800);
    rd('{8'hff});
    wr(16'h8000, '{8'h00, 8'h00}, 1'b1);
    poll();
    ptr(16'h8000);
    rd('{8'h0e});
    wr(16'h8000, '{8'h00}, 1'b1);
    poll();
    wr(16'h1800, '{8'h77}, 1'b1);
    poll();
    ptr(16'h1800);
    rd('{8'h77});
  endtask
  // Lock freezes the control bits
  task automatic t_lock();
    wr(16'h8000, '{8'h09}, 1'b1);
    poll();
    wr(16'h8000, '{8'h00}, 1'b1);
    poll();
    ptr(16'h8000);
    rd('{8'h09, 8'h09});
    wr(16'h1800, '{8'h55}, 1'b0);
    poll();
  endtask
  //----------------------------------------------
  // Clock, verdict, watchdog, main sequence
  //----------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hang well past the expected run length
  initial begin
    repeat (90000) @(negedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_delivery();
    t_foreign();
    t_write();
    t_page();
    t_protect();
    t_lock();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
